/* File: rtl/alo_params.svh */
// Register indices, reset values and limits of the level/curve block
`ifndef ALO_PARAMS_SVH
`define ALO_PARAMS_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define ALO_IDX_AI1_MODE  12'h31C
`define ALO_IDX_AI2_MODE  12'h31D
`define ALO_IDX_SRC       12'h32C
`define ALO_IDX_UPPER     12'h32D
`define ALO_IDX_LOWER     12'h32E
`define ALO_IDX_CURVE     12'h332
`define ALO_IDX_PT0       12'h339
`define ALO_IDX_PTN       12'h34A
`define ALO_IDX_DIR       12'h350
`define ALO_IDX_STATUS    12'h351
`define ALO_IDX_MASK      12'h352
`define ALO_IDX_STATE     12'h353

// ------------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------------
`define ALO_RST_UPPER     16'h0032
`define ALO_RST_LOWER     16'h000A
`define ALO_RST_AI2_LOW   16'h0190
`define ALO_PCT_MAX       16'h0064
`define ALO_VOLT_MAX      16'h03E8
`define ALO_AMP_MAX       16'h07D0
`define ALO_AI2_VOLT_MODE 16'h0001
`define ALO_AI1_BIPOLAR   16'h0003
`define ALO_NPTS          18
`define ALO_RESP_OKAY     2'h0
`define ALO_RESP_SLVERR   2'h2

// Status bit positions
`define ALO_ST_RISE       0
`define ALO_ST_FALL       1
`define ALO_ST_LOSS       2

`endif

/* File: rtl/alo_pkg.sv */
// Types shared by the level/curve block
package alo_pkg;

    typedef enum logic [1:0] {
        ALO_SRC_AI1   = 2'b00,
        ALO_SRC_AI2   = 2'b01,
        ALO_SRC_EXT10 = 2'b10,
        ALO_SRC_EXT11 = 2'b11
    } alo_src_t;

    typedef enum logic [1:0] {
        ALO_CRV_NORMAL = 2'b00,
        ALO_CRV_ONE    = 2'b01,
        ALO_CRV_TWO    = 2'b10,
        ALO_CRV_ALL    = 2'b11
    } alo_curve_t;

endpackage

/* File: rtl/alo_interp.sv */
// Three-point piecewise linear curve
`timescale 1ns/1ps
module alo_interp (
    input  logic        [15:0] x,
    input  logic        [15:0] x0,
    input  logic signed [15:0] y0,
    input  logic        [15:0] x1,
    input  logic signed [15:0] y1,
    input  logic        [15:0] x2,
    input  logic signed [15:0] y2,
    output logic signed [15:0] y
);

    function automatic logic signed [15:0] seg(
        input logic        [15:0] xa,
        input logic        [15:0] xb,
        input logic signed [15:0] ya,
        input logic signed [15:0] yb,
        input logic        [15:0] xi
    );
        logic signed [17:0] dy;
        logic signed [17:0] dx;
        logic signed [35:0] prod;
        logic signed [35:0] den;
        logic signed [35:0] q;
        dy   = 18'(yb) - 18'(ya);
        dx   = $signed({2'b00, 16'(xi - xa)});
        prod = dy * dx;
        den  = $signed({20'h00000, 16'(xb - xa)});
        q    = prod / den;
        seg  = 16'(ya + q[15:0]);
    endfunction

    // Zero below the lowest point, flat above the highest
    wire below = x < x0;
    wire lower = x < x1;
    wire upper = x < x2;

    assign y = below ? 16'sh0000 :
               lower ? seg(x0, x1, y0, y1, x) :
               upper ? seg(x1, x2, y1, y2, x) : y2;

endmodule

/* File: rtl/alo_level_curve.sv */
// Analog level output, curve selection and input-loss detection
//
// Notes on behaviour
// RULE1 - Selector 0,1,2,3 compares input one, two, extension ten, eleven.
// RULE2 - Level output goes high when selected level exceeds upper level.
// RULE3 - Level output goes low when selected level falls below lower level.
// RULE4 - Software keeps the upper level strictly above the lower level.
// RULE5 - Upper and lower levels are signed 16-bit, -100 to 100 percent.
// RULE6 - Curve selector 3 scales inputs one and two by all curve points.
// RULE7 - Curve selector 3 also puts extension ten and eleven on points.
// RULE8 - In curve mode direction follows the curve value sign only.
// RULE9 - Bipolar input one uses a second point set for negative half.
// RULE10 - Input two below its lowest point starts the input-loss action.
// RULE11 - Lowest point of input two is 0-10 V or 0-20 mA by mode.
// RULE12 - Between adjacent curve points the percentage is interpolated.
// RULE13 - Input two below its lowest point gives zero percent.
// RULE14 - Between the two levels the level output keeps its state.
`timescale 1ns/1ps
`include "alo_params.svh"
module alo_level_curve (
    input  logic               clock,
    input  logic               sys_rst,
    input  logic        [15:0] s_axi_awaddr,
    input  logic               s_axi_awvalid,
    output logic               s_axi_awready,
    input  logic        [31:0] s_axi_wdata,
    input  logic        [3:0]  s_axi_wstrb,
    input  logic               s_axi_wvalid,
    output logic               s_axi_wready,
    output logic        [1:0]  s_axi_bresp,
    output logic               s_axi_bvalid,
    input  logic               s_axi_bready,
    input  logic        [15:0] s_axi_araddr,
    input  logic               s_axi_arvalid,
    output logic               s_axi_arready,
    output logic        [31:0] s_axi_rdata,
    output logic        [1:0]  s_axi_rresp,
    output logic               s_axi_rvalid,
    input  logic               s_axi_rready,
    input  logic signed [15:0] analog_input_one,
    input  logic signed [15:0] analog_input_two,
    input  logic signed [15:0] extension_input_ten,
    input  logic signed [15:0] extension_input_eleven,
    input  logic signed [15:0] ai1_raw,
    input  logic        [15:0] ai2_raw,
    output logic               level_driven_output,
    output logic               input_loss_active,
    output logic signed [15:0] ai1_pct,
    output logic signed [15:0] ai2_pct,
    output logic               ai1_curve_en,
    output logic               ai2_curve_en,
    output logic               ext10_curve_en,
    output logic               ext11_curve_en,
    output logic               cmd_reverse,
    output logic               irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] wr16(
        input logic [15:0] old,
        input logic [31:0] d,
        input logic [3:0]  s
    );
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] sat_pct(input logic [15:0] v);
        if ($signed(v) > $signed(`ALO_PCT_MAX))
            sat_pct = `ALO_PCT_MAX;
        else if ($signed(v) < -$signed(`ALO_PCT_MAX))
            sat_pct = 16'(-`ALO_PCT_MAX);
        else
            sat_pct = v;
    endfunction

    function automatic logic [15:0] pt_default(input int i);
        case (i)
            0:       pt_default = `ALO_RST_AI2_LOW;
            2:       pt_default = 16'h04B0;
            3:       pt_default = 16'h1388;
            4:       pt_default = 16'h07D0;
            5:       pt_default = 16'h2710;
            8:       pt_default = 16'h01F4;
            9:       pt_default = 16'h1388;
            10:      pt_default = 16'h03E8;
            11:      pt_default = 16'h2710;
            14:      pt_default = 16'h01F4;
            15:      pt_default = 16'hEC78;
            16:      pt_default = 16'h03E8;
            17:      pt_default = 16'hD8F0;
            default: pt_default = 16'h0000;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] src_r;
    logic [15:0] upper_r;
    logic [15:0] lower_r;
    logic [15:0] curve_r;
    logic [15:0] ai1_mode_r;
    logic [15:0] ai2_mode_r;
    logic [15:0] dir_r;
    logic [2:0]  status_r;
    logic [2:0]  mask_r;
    logic [15:0] pts_r [0:`ALO_NPTS-1];

    logic        aw_got_r;
    logic        w_got_r;
    logic [15:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire  [11:0] widx    = awaddr_r[13:2];
    wire  [11:0] ridx    = s_axi_araddr[13:2];
    wire         do_wr   = aw_got_r && w_got_r && !s_axi_bvalid;
    wire         do_rd   = s_axi_arvalid && s_axi_arready;
    wire         w_is_pt = widx >= `ALO_IDX_PT0 && widx <= `ALO_IDX_PTN;
    wire         r_is_pt = ridx >= `ALO_IDX_PT0 && ridx <= `ALO_IDX_PTN;
    wire  [4:0]  wpt     = 5'(widx - `ALO_IDX_PT0);
    wire  [4:0]  rpt     = 5'(ridx - `ALO_IDX_PT0);
    wire         w_known = w_is_pt || widx == `ALO_IDX_SRC
                         || widx == `ALO_IDX_UPPER
                         || widx == `ALO_IDX_LOWER
                         || widx == `ALO_IDX_CURVE
                         || widx == `ALO_IDX_AI1_MODE
                         || widx == `ALO_IDX_AI2_MODE
                         || widx == `ALO_IDX_DIR
                         || widx == `ALO_IDX_MASK;
    wire         st_rd   = do_rd && ridx == `ALO_IDX_STATUS;
    wire  [15:0] low_max = (ai2_mode_r == `ALO_AI2_VOLT_MODE)
                         ? `ALO_VOLT_MAX : `ALO_AMP_MAX;
    wire  [15:0] low_wr  = wr16(pts_r[0], wdata_r, wstrb_r);
    wire  [15:0] low_sat = (low_wr > low_max) ? low_max : low_wr; // RULE11

    logic        rd_hit;
    logic [15:0] rd_val;

    always_comb begin
        rd_hit = 1'b1;
        rd_val = 16'h0000;
        if (r_is_pt) begin
            rd_val = pts_r[rpt];
        end else begin
            case (ridx)
                `ALO_IDX_SRC:      rd_val = src_r;
                `ALO_IDX_UPPER:    rd_val = upper_r;
                `ALO_IDX_LOWER:    rd_val = lower_r;
                `ALO_IDX_CURVE:    rd_val = curve_r;
                `ALO_IDX_AI1_MODE: rd_val = ai1_mode_r;
                `ALO_IDX_AI2_MODE: rd_val = ai2_mode_r;
                `ALO_IDX_DIR:      rd_val = dir_r;
                `ALO_IDX_STATUS:   rd_val = {13'h0000, status_r};
                `ALO_IDX_MASK:     rd_val = {13'h0000, mask_r};
                `ALO_IDX_STATE:    rd_val = {9'h000, cmd_reverse,
                                             ext11_curve_en, ext10_curve_en,
                                             ai2_curve_en, ai1_curve_en,
                                             input_loss_active,
                                             level_driven_output};
                default:           rd_hit = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 16'h0000;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ALO_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_wr) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_known ? `ALO_RESP_OKAY : `ALO_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            src_r      <= 16'h0000;
            upper_r    <= `ALO_RST_UPPER;
            lower_r    <= `ALO_RST_LOWER;
            curve_r    <= 16'h0000;
            ai1_mode_r <= 16'h0000;
            ai2_mode_r <= 16'h0000;
            dir_r      <= 16'h0000;
            mask_r     <= 3'h0;
            for (int i = 0; i < `ALO_NPTS; i++) begin
                pts_r[i] <= pt_default(i);
            end
        end else if (do_wr) begin
            if (w_is_pt && wpt == 5'h00) begin
                pts_r[0] <= low_sat; // RULE11
            end else if (w_is_pt) begin
                pts_r[wpt] <= wr16(pts_r[wpt], wdata_r, wstrb_r);
            end
            case (widx)
                `ALO_IDX_SRC:      src_r <= wr16(src_r, wdata_r, wstrb_r);
                `ALO_IDX_UPPER:    upper_r <= sat_pct(
                                       wr16(upper_r, wdata_r, wstrb_r)); // RULE5
                `ALO_IDX_LOWER:    lower_r <= sat_pct(
                                       wr16(lower_r, wdata_r, wstrb_r)); // RULE5
                `ALO_IDX_CURVE:    curve_r <= wr16(curve_r, wdata_r, wstrb_r);
                `ALO_IDX_AI1_MODE: ai1_mode_r <= wr16(ai1_mode_r, wdata_r,
                                                      wstrb_r);
                `ALO_IDX_AI2_MODE: ai2_mode_r <= wr16(ai2_mode_r, wdata_r,
                                                      wstrb_r);
                `ALO_IDX_DIR:      dir_r <= wr16(dir_r, wdata_r, wstrb_r);
                `ALO_IDX_MASK:     mask_r <= wdata_r[2:0];
                default:           ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ALO_RESP_OKAY;
        end else if (do_rd) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {16'h0000, rd_val};
            s_axi_rresp   <= rd_hit ? `ALO_RESP_OKAY : `ALO_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Level comparator with hysteresis
    // ------------------------------------------------------------------
    alo_pkg::alo_src_t src_sel;
    logic signed [15:0] sel_lvl;

    assign src_sel = alo_pkg::alo_src_t'(src_r[1:0]);

    always_comb begin
        case (src_sel) // RULE1
            alo_pkg::ALO_SRC_AI1:   sel_lvl = analog_input_one;
            alo_pkg::ALO_SRC_AI2:   sel_lvl = analog_input_two;
            alo_pkg::ALO_SRC_EXT10: sel_lvl = extension_input_ten;
            alo_pkg::ALO_SRC_EXT11: sel_lvl = extension_input_eleven;
            default:                sel_lvl = analog_input_one;
        endcase
    end

    // Upper test first; relies on software keeping upper above lower
    wire above = sel_lvl > $signed(upper_r); // RULE4
    wire below = sel_lvl < $signed(lower_r);
    wire dout_nxt = above ? 1'b1 : below ? 1'b0 : level_driven_output;

    // ------------------------------------------------------------------
    // Curve scaling
    // ------------------------------------------------------------------
    alo_pkg::alo_curve_t curve_sel;
    logic signed [15:0] ai2_y;
    logic signed [15:0] ai1p_y;
    logic signed [15:0] ai1n_y;

    assign curve_sel = alo_pkg::alo_curve_t'(curve_r[1:0]);

    wire        crv_one  = curve_sel == alo_pkg::ALO_CRV_ONE
                        || curve_sel == alo_pkg::ALO_CRV_ALL;
    wire        crv_two  = curve_sel == alo_pkg::ALO_CRV_TWO
                        || curve_sel == alo_pkg::ALO_CRV_ALL;
    wire        crv_any  = curve_sel != alo_pkg::ALO_CRV_NORMAL;
    wire        ai1_neg  = ai1_mode_r == `ALO_AI1_BIPOLAR && ai1_raw < 0;
    wire [15:0] ai1_mag  = ai1_raw < 0 ? 16'(-ai1_raw) : 16'(ai1_raw);
    wire        loss     = ai2_raw < pts_r[0];

    alo_interp u_ai2 (
        .x  (ai2_raw),
        .x0 (pts_r[0]),
        .y0 (pts_r[1]),
        .x1 (pts_r[2]),
        .y1 (pts_r[3]),
        .x2 (pts_r[4]),
        .y2 (pts_r[5]),
        .y  (ai2_y)
    );

    alo_interp u_ai1_pos (
        .x  (ai1_mag),
        .x0 (pts_r[6]),
        .y0 (pts_r[7]),
        .x1 (pts_r[8]),
        .y1 (pts_r[9]),
        .x2 (pts_r[10]),
        .y2 (pts_r[11]),
        .y  (ai1p_y)
    );

    alo_interp u_ai1_neg (
        .x  (ai1_mag),
        .x0 (pts_r[12]),
        .y0 (pts_r[13]),
        .x1 (pts_r[14]),
        .y1 (pts_r[15]),
        .x2 (pts_r[16]),
        .y2 (pts_r[17]),
        .y  (ai1n_y)
    );

    wire signed [15:0] ai1_y   = ai1_neg ? ai1n_y : ai1p_y; // RULE9
    wire signed [15:0] freq_y  = crv_one ? ai1_y : ai2_y;
    wire               rev_nxt = crv_any ? freq_y < 0 : dir_r[0]; // RULE8

    // ------------------------------------------------------------------
    // Outputs and interrupt status
    // ------------------------------------------------------------------
    wire [2:0] ev;
    assign ev[`ALO_ST_RISE] = dout_nxt && !level_driven_output;
    assign ev[`ALO_ST_FALL] = !dout_nxt && level_driven_output;
    assign ev[`ALO_ST_LOSS] = loss && !input_loss_active;

    // Set wins over the clear from a status read
    wire [2:0] status_nxt = (st_rd ? 3'h0 : status_r) | ev;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            level_driven_output <= 1'b0;
            input_loss_active   <= 1'b0;
            ai1_pct             <= 16'sh0000;
            ai2_pct             <= 16'sh0000;
            ai1_curve_en        <= 1'b0;
            ai2_curve_en        <= 1'b0;
            ext10_curve_en      <= 1'b0;
            ext11_curve_en      <= 1'b0;
            cmd_reverse         <= 1'b0;
            status_r            <= 3'h0;
            irq                 <= 1'b0;
        end else begin
            level_driven_output <= dout_nxt; // RULE2 RULE3 RULE14
            input_loss_active   <= loss; // RULE10
            ai1_pct             <= ai1_y; // RULE12
            ai2_pct             <= ai2_y; // RULE13
            ai1_curve_en        <= crv_one; // RULE6
            ai2_curve_en        <= crv_two; // RULE6
            ext10_curve_en      <= crv_one; // RULE7
            ext11_curve_en      <= crv_two; // RULE7
            cmd_reverse         <= rev_nxt; // RULE8
            status_r            <= status_nxt;
            irq                 <= |(status_nxt & mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_src_ext11: assert property ( // RULE1
        @(posedge clock) disable iff (sys_rst)
        src_r[1:0] == 2'b11 && extension_input_eleven > $signed(upper_r)
        |=> level_driven_output)
        else $error("extension eleven not compared");
    a_level_rise: assert property ( // RULE2
        @(posedge clock) disable iff (sys_rst)
        sel_lvl > $signed(upper_r) |=> level_driven_output)
        else $error("level output not raised");
    a_level_fall: assert property ( // RULE3
        @(posedge clock) disable iff (sys_rst)
        sel_lvl < $signed(lower_r) && !(sel_lvl > $signed(upper_r))
        |=> !level_driven_output)
        else $error("level output not dropped");
    a_level_range: assert property ( // RULE5
        @(posedge clock) disable iff (sys_rst)
        $signed(upper_r) <= $signed(`ALO_PCT_MAX)
        && $signed(lower_r) >= -$signed(`ALO_PCT_MAX))
        else $error("level setting out of range");
    a_curve_all: assert property ( // RULE7
        @(posedge clock) disable iff (sys_rst)
        curve_r[1:0] == 2'b11 |=> ai1_curve_en && ai2_curve_en
        && ext10_curve_en && ext11_curve_en)
        else $error("curve select 3 not applied");
    a_dir_sign: assert property ( // RULE8
        @(posedge clock) disable iff (sys_rst)
        crv_one |=> cmd_reverse == ($past(ai1_y) < 0))
        else $error("direction not from curve sign");
    a_neg_half: assert property ( // RULE9
        @(posedge clock) disable iff (sys_rst)
        ai1_neg |=> ai1_pct == $past(ai1n_y))
        else $error("negative half set not used");
    a_loss_start: assert property ( // RULE10
        @(posedge clock) disable iff (sys_rst)
        ai2_raw < pts_r[0]
        |=> input_loss_active && (status_r[2] || $past(input_loss_active)))
        else $error("input loss not started");
    a_low_limit: assert property ( // RULE11
        @(posedge clock) disable iff (sys_rst)
        $rose(do_wr) && w_is_pt && wpt == 5'h00
        && ai2_mode_r == `ALO_AI2_VOLT_MODE |=> pts_r[0] <= `ALO_VOLT_MAX)
        else $error("voltage lowest point above limit");
    a_mid_point: assert property ( // RULE12
        @(posedge clock) disable iff (sys_rst)
        ai2_raw == pts_r[2] && pts_r[0] < pts_r[2] && pts_r[2] < pts_r[4]
        |=> ai2_pct == $past(pts_r[3]))
        else $error("mid point value wrong");
    a_ai2_zero: assert property ( // RULE13
        @(posedge clock) disable iff (sys_rst)
        ai2_raw < pts_r[0] |=> ai2_pct == 16'sh0000)
        else $error("below lowest point not zero");
    a_level_hold: assert property ( // RULE14
        @(posedge clock) disable iff (sys_rst)
        !(sel_lvl > $signed(upper_r)) && !(sel_lvl < $signed(lower_r))
        |=> $stable(level_driven_output))
        else $error("level output changed between levels");

endmodule

/* File: verification/alo_level_curve_tb.sv */
// Self-checking bench of the level output and curve block
`timescale 1ns/1ps
`include "alo_params.svh"
module alo_level_curve_tb;
    logic               clock = 0;
    logic               sys_rst = 1;
    logic        [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic        [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic        [3:0]  s_axi_wstrb = 4'hF;
    logic        [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic               s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic               s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic               s_axi_rvalid, level_driven_output, irq;
    logic signed [15:0] analog_input_one = 0, analog_input_two = 0;
    logic signed [15:0] extension_input_ten = 0, extension_input_eleven = 0;
    logic signed [15:0] ai1_raw = 16'h00FA, ai1_pct, ai2_pct;
    logic        [15:0] ai2_raw = 16'h03E8;
    logic               input_loss_active, ai1_curve_en, ai2_curve_en;
    logic               ext10_curve_en, ext11_curve_en, cmd_reverse;
    int                 err_count = 0;
    int                 num_checks = 0;
    int regs[5][2] = '{'{12'h32C, 0}, '{12'h32D, 50}, '{12'h32E, 10},
                       '{12'h332, 0}, '{12'h339, 400}};
    int rows[9][6] = '{'{0, 60, 30, 30, 30, 1}, '{1, -50, 30, 30, 30, 1},
        '{2, 30, 30, -20, 30, 0}, '{3, 30, 30, 30, 70, 1},
        '{0, 5, 30, 30, 90, 0}, '{1, 90, 50, 30, 30, 0},
        '{1, 0, 100, 0, 0, 1}, '{1, 0, 10, 0, 0, 1}, '{1, 0, 9, 0, 0, 0}};
    int crv[4] = '{0, 10, 5, 15};

    alo_level_curve u_dut (.*);

    always #2 clock = ~clock;

    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wreg(logic [11:0] i, logic [15:0] d);
        bit a, w, b;
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clock);
            a = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge clock);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rreg(logic [11:0] i);
        bit a, b;
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clock);
            a = s_axi_arready;
            b = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge clock);
            if (a) s_axi_arvalid <= 1'b0;
        end while (!b);
        s_axi_rready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        foreach (regs[k]) begin
            rreg(12'(regs[k][0]));
            chk("reg", regs[k][1], rd);
        end
        rreg(12'h0FF);
        chk("unmapped", 32'h2, {30'h0, rs});
        wreg(`ALO_IDX_MASK, 16'h0001);
        foreach (rows[k]) begin
            wreg(`ALO_IDX_SRC, 16'(rows[k][0]));
            analog_input_one <= 16'(rows[k][1]);
            analog_input_two <= 16'(rows[k][2]);
            extension_input_ten <= 16'(rows[k][3]);
            extension_input_eleven <= 16'(rows[k][4]);
            settle();
            chk("dout", rows[k][5], level_driven_output);
        end
        chk("irq", 1, irq);
        rreg(`ALO_IDX_STATUS);
        chk("status", 3, rd);
        settle();
        chk("irq", 0, irq);
        wreg(`ALO_IDX_MASK, 16'h0000);
        ai2_raw <= 16'h0064;
        settle();
        chk("loss", 1, input_loss_active);
        chk("irq", 0, irq);
        wreg(`ALO_IDX_MASK, 16'h0004);
        settle();
        chk("irq", 1, irq);
        wreg(`ALO_IDX_DIR, 16'h0001);
        for (int c = 0; c < 4; c++) begin
            wreg(`ALO_IDX_CURVE, 16'(c));
            settle();
            chk("curve", crv[c], {ai1_curve_en, ai2_curve_en,
                ext10_curve_en, ext11_curve_en});
        end
        chk("ai1_pct", 32'h09C4, ai1_pct);
        chk("ai2_pct", 0, ai2_pct);
        chk("reverse", 0, cmd_reverse);
        wreg(`ALO_IDX_AI1_MODE, 16'h0003);
        chk("bresp", 0, rs);
        ai1_raw <= 16'hFF06;
        settle();
        chk("ai1_neg", 32'hFFFFF63C, ai1_pct);
        chk("reverse", 1, cmd_reverse);
        wreg(`ALO_IDX_AI2_MODE, 16'h0001);
        wreg(`ALO_IDX_PT0, 16'h0FFF);
        rreg(`ALO_IDX_PT0);
        chk("lowest", 32'h03E8, rd);
        ai2_raw <= 16'h04B0;
        settle();
        chk("ai2_pct", 32'h1388, ai2_pct);
        wreg(12'h0FF, 16'h0001);
        chk("bresp", 2, rs);
        wreg(`ALO_IDX_LOWER, 16'hFF38);
        rreg(`ALO_IDX_LOWER);
        chk("lower", 32'hFF9C, rd);
        sys_rst <= 1'b1;
        settle();
        chk("dout", 0, level_driven_output);
        sys_rst <= 1'b0;
        @(posedge clock);
        rreg(`ALO_IDX_LOWER);
        chk("lower", 32'h000A, rd);
        complete_run();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        complete_run();
    end
endmodule
